// ==== rtl/tcr_pkg.sv ====
// Constants for the timer capture readback block
`default_nettype none
package tcr_pkg;
    localparam int unsigned TCR_AW = 8;
    localparam int unsigned TCR_DW = 32;
    localparam logic [7:0] TCR_OFF_PULSE = 8'h48;
    localparam logic [7:0] TCR_OFF_RISE = 8'h4c;
    localparam logic [7:0] TCR_OFF_FALL = 8'h50;
    localparam logic [7:0] TCR_OFF_COUNT = 8'h54;
    localparam logic [31:0] TCR_RST_VAL = 32'h0000_0000;
    localparam int unsigned TCR_LIN_W = 11;
    localparam int unsigned TCR_POW_W = 4;
    localparam logic [10:0] TCR_LIN_RST = 11'h000;
    localparam logic [3:0] TCR_POW_RST = 4'h0;
    localparam int unsigned TCR_PRE_W = 26;
    localparam logic [25:0] TCR_PRE_ONE = 26'h0000001;
endpackage
`default_nettype wire

// ==== rtl/tcr_prescaler.sv ====
// Counter tick generator: source / (linear + 1) / 2^power
`default_nettype none
module tcr_prescaler
    import tcr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [10:0] linear_prescale_field,
    input wire logic [3:0] power_of_two_prescale_field,
    // Tick out
    output logic tick
);
    logic [25:0] cnt_q;
    logic [25:0] limit;

    assign limit = ((26'(linear_prescale_field) + TCR_PRE_ONE) << power_of_two_prescale_field)
                   - TCR_PRE_ONE;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!run || cnt_q >= limit) begin
            cnt_q <= '0; // R6
        end else begin
            cnt_q <= cnt_q + TCR_PRE_ONE;
        end
    end

    assign tick = run && (cnt_q >= limit); // R6
endmodule // tcr_prescaler
`default_nettype wire

// ==== rtl/tcr_capture.sv ====
// Capture and readback view of one timer channel
`default_nettype none
// Operation
// R1: Read-only register at 0x48 returns the pulse value in use; resets to zero.
// R2: Counter latched on capture rising edge, readable at 0x4C; resets to zero.
// R3: Counter latched on capture falling edge, readable at 0x50; resets to zero.
// R4: Live counter readable at 0x54 without side effects; resets to zero.
// R5: Capture and counter readings valid only with bus clock as counter source.
// R6: Counter advances at source / (linear field + 1) / 2^power field.
// R7: Written pulse setting takes effect only on update or start request.
// R8: Each capture register updates whole in one cycle; reads never see a mix.
module tcr_capture
    import tcr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Timer control
    input wire logic counter_run,
    input wire logic counter_clear,
    input wire logic [10:0] linear_prescale_field,
    input wire logic [3:0] power_of_two_prescale_field,
    input wire logic [31:0] pulse_setting_register,
    input wire logic update_req,
    input wire logic start_req,
    input wire logic bus_clock_source,
    // Capture pin
    input wire logic capture_in,
    // Status
    output logic readback_valid,
    output logic [31:0] counter_value
);
    // ============================================================
    // Capture pin synchroniser; only the second stage feeds logic
    logic sync1_q;
    logic sync2_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= capture_in;
            sync2_q <= sync1_q;
        end
    end

    // ============================================================
    // Prescaler
    logic tick;

    // Counter_run low restarts the divider
    tcr_prescaler u_pre (
        .clock(clock),
        .rst_n(rst_n),
        .run(counter_run),
        .linear_prescale_field(linear_prescale_field),
        .power_of_two_prescale_field(power_of_two_prescale_field),
        .tick(tick)
    );

    // ============================================================
    // Counter
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic [31:0] count_inc;

    assign count_inc = count_q + 32'h0000_0001; // R6

    // Clear wins over a tick in the same cycle
    always_comb begin
        count_d = count_q;
        if (counter_clear) begin
            count_d = TCR_RST_VAL;
        end else if (tick) begin
            count_d = count_inc; // R6
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= TCR_RST_VAL;
        end else begin
            count_q <= count_d;
        end
    end

    // Live count straight from the register, so reads have no side effect
    assign counter_value = count_q; // R4

    // ============================================================
    // Active pulse, loaded only by an update or start request
    logic [31:0] pulse_q;
    logic [31:0] pulse_d;

    // Takes whatever pulse setting stands in the request cycle
    always_comb begin
        pulse_d = pulse_q;
        if (update_req || start_req) begin
            pulse_d = pulse_setting_register; // R7
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= TCR_RST_VAL; // R1
        end else begin
            pulse_q <= pulse_d;
        end
    end

    // ============================================================
    // Edge captures; entry C_FALL watches the inverted pin
    localparam int unsigned NCAP = 2;
    localparam int unsigned C_RISE = 0;
    localparam int unsigned C_FALL = 1;
    localparam logic [NCAP-1:0] CAP_INV = 2'h2;
    wire logic [NCAP-1:0][31:0] cap_word;

    for (genvar g = 0; g < NCAP; g++) begin : g_cap
        logic level;
        logic hist_q;
        logic edge_det;
        logic [31:0] cap_q;
        logic [31:0] cap_d;

        // With the pin inverted, both entries look for a rise
        assign level = sync2_q ^ CAP_INV[g];
        assign edge_det = level && !hist_q; // R2 R3

        // History resets to the idle level of the pin, so reset makes no edge
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                hist_q <= CAP_INV[g];
            end else begin
                hist_q <= level;
            end
        end

        // Whole word loads at one edge; a read sees old or new, never a mix
        always_comb begin
            cap_d = cap_q;
            if (edge_det) begin
                cap_d = count_q; // R2 R3 R8
            end
        end

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cap_q <= TCR_RST_VAL;
            end else begin
                cap_q <= cap_d; // R8
            end
        end

        // Packed out so the view table can index the entries
        assign cap_word[g] = cap_q;
    end : g_cap

    // ============================================================
    // Readback validity follows the counter's clock source
    // Captures and live count mean nothing with another source
    assign readback_valid = bus_clock_source; // R5

    // ============================================================
    // Register view table; writes have no effect, unmapped reads zero
    localparam int unsigned NREG = 4;
    localparam int unsigned V_PULSE = 0;
    localparam int unsigned V_RISE = 1;
    localparam int unsigned V_FALL = 2;
    localparam int unsigned V_COUNT = 3;
    wire logic [NREG-1:0][7:0] view_off;
    wire logic [NREG-1:0][31:0] view_word;
    wire logic [NREG-1:0] view_hit;
    wire logic [NREG-1:0] rd_sel;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // One compare per entry against its fixed offset
    for (genvar v = 0; v < NREG; v++) begin : g_view
        if (v == V_PULSE) begin : g_pulse
            assign view_off[v] = TCR_OFF_PULSE; // R1
            assign view_word[v] = pulse_q; // R1
        end else if (v == V_RISE) begin : g_rise
            assign view_off[v] = TCR_OFF_RISE; // R2
            assign view_word[v] = cap_word[C_RISE]; // R2
        end else if (v == V_FALL) begin : g_fall
            assign view_off[v] = TCR_OFF_FALL; // R3
            assign view_word[v] = cap_word[C_FALL]; // R3
        end else if (v == V_COUNT) begin : g_count
            assign view_off[v] = TCR_OFF_COUNT; // R4
            assign view_word[v] = count_q; // R4
        end
        assign view_hit[v] = (reg_addr == view_off[v]);
        assign rd_sel[v] = reg_rd && view_hit[v];
    end : g_view

    // Offsets are distinct, so at most one entry matches
    always_comb begin
        rdata_d = TCR_RST_VAL;
        for (int unsigned k = 0; k < NREG; k++) begin
            if (rd_sel[k]) begin
                rdata_d = view_word[k];
            end
        end
    end

    // ============================================================
    // Read data register: stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= TCR_RST_VAL;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
endmodule // tcr_capture
`default_nettype wire

// ==== dv/tcr_capture_monitor.sv ====
// Port checker for tcr_capture
`default_nettype none
module tcr_capture_monitor
    import tcr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic counter_run,
    input wire logic counter_clear,
    input wire logic [31:0] pulse_setting_register,
    input wire logic update_req,
    input wire logic capture_in,
    input wire logic [31:0] counter_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    idle_zero_a: assert property (!reg_rd |=> reg_rdata == 0) else $error("idle");
    clear_zero_a: assert property (counter_clear |=> counter_value == 0) else $error("clr");
    step_one_a: assert property (
        !counter_clear |=> counter_value - $past(counter_value) <= 1) else $error("step");
    idle_hold_a: assert property (
        !counter_run && !counter_clear |=> $stable(counter_value)) else $error("hold");
    count_read_a: assert property (
        reg_rd && reg_addr == TCR_OFF_COUNT |=> reg_rdata == $past(counter_value))
        else $error("cnt");
    pulse_read_a: assert property (
        update_req ##1 (reg_rd && reg_addr == TCR_OFF_PULSE)
        |=> reg_rdata == $past(pulse_setting_register, 2)) else $error("pulse");
    rise_cap_a: assert property (
        $rose(capture_in) ##3 (reg_rd && reg_addr == TCR_OFF_RISE)
        |=> reg_rdata == $past(counter_value, 2)) else $error("rise");
    fall_cap_a: assert property (
        $fell(capture_in) ##3 (reg_rd && reg_addr == TCR_OFF_FALL)
        |=> reg_rdata == $past(counter_value, 2)) else $error("fall");
    cover property (counter_clear);
    cover property ($fell(capture_in));
    cover property (update_req);
endmodule // tcr_capture_monitor
`default_nettype wire

// ==== dv/test_tcr_capture.sv ====
// Random bench for tcr_capture
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch %0t compare failed", $time); end end
module test_tcr_capture;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, wr = 0, rs = 0, run = 0, clr = 0, upd = 0, st = 0, bcs = 0;
    logic cap = 0, rv;
    logic [7:0] a = 0;
    logic [31:0] ps = 0, q;
    logic [10:0] lin = 0;
    logic [3:0] pw = 0;
    int miscompares = 0, check_count = 0, cyc = 0, n;
    tcr_capture uut (.clock, .rst_n, .reg_addr(a), .reg_wdata(ps), .reg_wr(wr), .reg_rd(rs),
        .reg_rdata(q), .counter_run(run), .counter_clear(clr), .linear_prescale_field(lin),
        .power_of_two_prescale_field(pw), .pulse_setting_register(ps), .update_req(upd),
        .start_req(st), .bus_clock_source(bcs), .capture_in(cap), .readback_valid(rv),
        .counter_value());
    always #2.5 clock = ~clock;
    always @(posedge clock) if (++cyc == 4000) begin miscompares++; close_out; end
    function automatic logic [31:0] ex(int k);
        return 32'(k / ((lin + 1) << pw));
    endfunction
    task automatic rd(input logic [7:0] r, input logic [31:0] e);
        @(posedge clock);
        {upd, st, wr, rs, a} <= {3'h0, 1'h1, r};
        @(posedge clock);
        rs <= 0;
        #1 `CHK(q, e)
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        n = $urandom(32'ha8d1);
        repeat (3) @(posedge clock);
        rst_n <= 1;
        for (int r = 'h44; r < 'h58; r += 4) rd(8'(r), 0);
        @(posedge clock) {ps, wr, a} <= {$urandom, 1'h1, 8'h48};
        rd(8'h48, 0);
        @(posedge clock) upd <= 1;
        rd(8'h48, ps);
        @(posedge clock) {ps, st} <= {~ps, 1'h1};
        rd(8'h48, ~ps);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock) {lin, pw, bcs, clr} <= {11'(i / 4 * i), 4'(i / 4), i[0], 1'h1};
            n = 1 + $urandom % 80;
            @(posedge clock) {clr, run} <= 2'h1;
            repeat (n) @(posedge clock);
            run <= 0;
            rd(8'h54, ex(n));
            `CHK(rv, bcs)
            @(posedge clock) cap <= 1;
            repeat (2) @(posedge clock);
            rd(8'h4c, ex(n));
            @(posedge clock) cap <= 0;
            repeat (2) @(posedge clock);
            rd(8'h50, ex(n));
        end
        @(posedge clock) {lin, pw, clr} <= {15'h0, 1'h1};
        @(posedge clock) {clr, run, cap} <= {2'h1, 1'h1};
        repeat (3) @(posedge clock);
        rd(8'h4c, 32'h0000_0002);
        close_out;
    end
endmodule // test_tcr_capture
bind tcr_capture tcr_capture_monitor mon (.clock, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
    .counter_run, .counter_clear, .pulse_setting_register, .update_req, .capture_in,
    .counter_value);
`default_nettype wire
